// ===== src/ext_irq_pkg.sv
// Package for the external interrupt source select block.
// Assumes a single system clock; all users reference it by scoped name.
package ext_irq_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned LINE_COUNT  = 16;
  localparam int unsigned GROUP_COUNT = 6;
  localparam int unsigned GROUP_PINS  = 16;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned PORT_SEL_W  = 4;
  localparam int unsigned PIN_SEL_W   = 2;
  localparam int unsigned PIN_SLOT_W  = 4;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] PORT_SEL_LOW_OFS  = 12'h400;
  localparam logic [11:0] PORT_SEL_HIGH_OFS = 12'h404;
  localparam logic [11:0] PIN_SEL_LOW_OFS   = 12'h408;
  localparam logic [11:0] PIN_SEL_HIGH_OFS  = 12'h40C;
  localparam logic [11:0] RISE_EN_OFS       = 12'h410;
  localparam logic [11:0] IRQ_STATUS_OFS    = 12'h420;
  localparam logic [11:0] IRQ_MASK_OFS      = 12'h424;

  // ----------------------------------------------------------------------
  // Reset values and field masks
  // ----------------------------------------------------------------------
  localparam logic [31:0] PORT_SEL_RESET = 32'h00000000;
  localparam logic [31:0] PIN_SEL_RESET  = 32'h32103210;
  localparam logic [31:0] PIN_SEL_MASK   = 32'h33333333;
  localparam logic [15:0] RISE_EN_RESET  = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

  // Port group codes; other codes have no group behind them
  localparam logic [3:0] GROUP_A_CODE = 4'h0;
  localparam logic [3:0] GROUP_B_CODE = 4'h1;
  localparam logic [3:0] GROUP_C_CODE = 4'h2;
  localparam logic [3:0] GROUP_D_CODE = 4'h3;
  localparam logic [3:0] GROUP_F_CODE = 4'h5;

  // Register bus request bundle
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : ext_irq_pkg

// ===== src/line_source_mux.sv
// One external interrupt line's source multiplexer.
// Assumes the pin bus is already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module line_source_mux #(
  parameter int unsigned LINE = 0
) (
  input  wire logic [95:0] pins,      // Six groups of sixteen pins
  input  wire logic [3:0]  port_sel,  // Port group code
  input  wire logic [1:0]  pin_sel,   // Pin within group of four
  output logic             src        // Selected source level
);

  // ----------------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------------
  logic [3:0] pin_idx;
  assign pin_idx = {LINE[3:2], pin_sel};

  // Undefined group codes read as a quiet line rather than a stray pin
  always_comb begin
    case (port_sel)
      ext_irq_pkg::GROUP_A_CODE: src = pins[{3'h0, pin_idx}];
      ext_irq_pkg::GROUP_B_CODE: src = pins[7'h10 + {3'h0, pin_idx}];
      ext_irq_pkg::GROUP_C_CODE: src = pins[7'h20 + {3'h0, pin_idx}];
      ext_irq_pkg::GROUP_D_CODE: src = pins[7'h30 + {3'h0, pin_idx}];
      ext_irq_pkg::GROUP_F_CODE: src = pins[7'h50 + {3'h0, pin_idx}];
      default:                   src = 1'b0;
    endcase
  end

endmodule : line_source_mux
`default_nettype wire

// ===== src/rise_detect.sv
// Rising edge detector for the sixteen selected sources.
// Assumes synchronous inputs; one flop of history per line.
`timescale 1ns/1ps
`default_nettype none
module rise_detect #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             rst_b,    // Async reset, active low
  input  wire logic [WIDTH-1:0] level,    // Current source levels
  output logic      [WIDTH-1:0] rose      // One-cycle rising pulses
);

  // ----------------------------------------------------------------------
  // History
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] prev;

  // Reset history low so a high source after reset reads as an edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rose = level & ~prev;

endmodule : rise_detect
`default_nettype wire

// ===== src/ext_irq_source_select.sv
// External interrupt source select: maps sixteen lines onto port pins.
// Assumes synchronous pin inputs and a single-cycle register master.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_source_select #(
  parameter int unsigned LINES = 16
) (
  input  wire logic        clk_sys,   // System clock, 50 MHz
  input  wire logic        rst_b,     // Async reset, active low
  input  wire logic [11:0] reg_addr,  // Register byte address
  input  wire logic [31:0] reg_wdata, // Write data
  input  wire logic        reg_wr,    // Write strobe
  input  wire logic        reg_rd,    // Read strobe
  output logic      [31:0] reg_rdata, // Read data, cycle after strobe
  input  wire logic [95:0] pins,      // Groups A..F, sixteen pins each
  output logic [LINES-1:0] line_src,  // Selected source per line
  output logic             irq        // Level interrupt request
);

  // ----------------------------------------------------------------------
  // Request bundle
  // ----------------------------------------------------------------------
  ext_irq_pkg::reg_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata,
                 wr: reg_wr, rd: reg_rd};

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0]      port_sel_low;
  logic [31:0]      port_sel_high;
  logic [31:0]      pin_sel_low;
  logic [31:0]      pin_sel_high;
  logic [15:0]      rising_edge_enables;
  logic [15:0]      irq_status;
  logic [15:0]      irq_mask;
  logic [LINES-1:0] src_now;
  logic [LINES-1:0] rose;

  // Port codes: both halves reset to group A
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_sel_low  <= ext_irq_pkg::PORT_SEL_RESET;
      port_sel_high <= ext_irq_pkg::PORT_SEL_RESET;
    end else if (req.wr) begin
      if (req.addr == ext_irq_pkg::PORT_SEL_LOW_OFS) begin
        port_sel_low <= req.wdata;
      end
      if (req.addr == ext_irq_pkg::PORT_SEL_HIGH_OFS) begin
        port_sel_high <= req.wdata;
      end
    end
  end

  // Pin codes: spare bits are never stored so they always read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_sel_low  <= ext_irq_pkg::PIN_SEL_RESET;
      pin_sel_high <= ext_irq_pkg::PIN_SEL_RESET;
    end else if (req.wr) begin
      if (req.addr == ext_irq_pkg::PIN_SEL_LOW_OFS) begin
        pin_sel_low <= req.wdata & ext_irq_pkg::PIN_SEL_MASK;
      end
      if (req.addr == ext_irq_pkg::PIN_SEL_HIGH_OFS) begin
        pin_sel_high <= req.wdata & ext_irq_pkg::PIN_SEL_MASK;
      end
    end
  end

  // Edge enables and interrupt mask
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rising_edge_enables <= ext_irq_pkg::RISE_EN_RESET;
      irq_mask            <= ext_irq_pkg::IRQ_MASK_RESET;
    end else if (req.wr) begin
      if (req.addr == ext_irq_pkg::RISE_EN_OFS) begin
        rising_edge_enables <= req.wdata[15:0];
      end
      if (req.addr == ext_irq_pkg::IRQ_MASK_OFS) begin
        irq_mask <= req.wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source selection per line
  // ----------------------------------------------------------------------
  logic [31:0] port_all [0:1];
  logic [31:0] pin_all  [0:1];
  assign port_all[0] = port_sel_low;
  assign port_all[1] = port_sel_high;
  assign pin_all[0]  = pin_sel_low;
  assign pin_all[1]  = pin_sel_high;

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      // Four bits per line; pin code in the low half of each nibble
      line_source_mux #(
        .LINE     (g)
      ) u_mux (
        .pins     (pins),
        .port_sel (port_all[g/8][(g%8)*4 +: 4]),
        .pin_sel  (pin_all[g/8][(g%8)*4 +: 2]),
        .src      (src_now[g])
      );
    end
  endgenerate

  rise_detect #(
    .WIDTH   (LINES)
  ) u_rise (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .level   (src_now),
    .rose    (rose)
  );

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  logic [15:0] clr_bits;
  logic [15:0] set_bits;
  assign clr_bits = (req.wr && req.addr == ext_irq_pkg::IRQ_STATUS_OFS) ?
                    req.wdata[15:0] : 16'h0000;
  assign set_bits = rose & rising_edge_enables;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= 16'h0000;
    end else begin
      irq_status <= (irq_status & ~clr_bits) | set_bits;
    end
  end

  // Registered outputs; irq trails the status bit by one cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq      <= 1'b0;
      line_src <= '0;
    end else begin
      irq      <= |(irq_status & irq_mask);
      line_src <= src_now;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped addresses and idle cycles read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (req.rd) begin
      case (req.addr)
        ext_irq_pkg::PORT_SEL_LOW_OFS:  reg_rdata <= port_sel_low;
        ext_irq_pkg::PORT_SEL_HIGH_OFS: reg_rdata <= port_sel_high;
        ext_irq_pkg::PIN_SEL_LOW_OFS:   reg_rdata <= pin_sel_low;
        ext_irq_pkg::PIN_SEL_HIGH_OFS:  reg_rdata <= pin_sel_high;
        ext_irq_pkg::RISE_EN_OFS:       reg_rdata <= {16'h0000,
                                                      rising_edge_enables};
        ext_irq_pkg::IRQ_STATUS_OFS:    reg_rdata <= {16'h0000, irq_status};
        ext_irq_pkg::IRQ_MASK_OFS:      reg_rdata <= {16'h0000, irq_mask};
        default:                        reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : ext_irq_source_select
`default_nettype wire

// ===== verification/ext_irq_checker_assertions.sv
// Checker: register readback, line routing and interrupt relations.
// Assumes only the top ports; bound into the block below the module.
`timescale 1ns/1ps
`default_nettype none
module ext_irq_checker #(
  parameter int unsigned LINES = 16
) (
  input wire logic             clk_sys,   // Clock
  input wire logic             rst_b,     // Reset, low
  input wire logic [11:0]      reg_addr,  // Address
  input wire logic [31:0]      reg_wdata, // Write data
  input wire logic             reg_wr,    // Write strobe
  input wire logic             reg_rd,    // Read strobe
  input wire logic [31:0]      reg_rdata, // Read data
  input wire logic [95:0]      pins,      // Pin groups
  input wire logic [LINES-1:0] line_src,  // Routed lines
  input wire logic             irq        // Interrupt
);
  // --------------------------------------------------------------
  // Shadow of the select, enable and mask registers
  // --------------------------------------------------------------
  logic [31:0]      slo, shi, plo, phi, k, j;
  logic [15:0]      en, msk;
  logic [LINES-1:0] exp_src;
  // Pin codes keep only their 2-bit fields; spare pairs are dropped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slo <= 32'h0;
      shi <= 32'h0;
      plo <= 32'h32103210;
      phi <= 32'h32103210;
      en  <= 16'h0;
      msk <= 16'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        12'h400: slo <= reg_wdata;
        12'h404: shi <= reg_wdata;
        12'h408: plo <= reg_wdata & 32'h33333333;
        12'h40C: phi <= reg_wdata & 32'h33333333;
        12'h410: en  <= reg_wdata[15:0];
        12'h424: msk <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end
  // Codes without a group behind them give a low source
  always_comb begin
    for (int n = 0; n < LINES; n++) begin
      k = (n < 8 ? slo : shi) >> (4 * (n % 8));
      j = (n < 8 ? plo : phi) >> (4 * (n % 8));
      exp_src[n] = (k[3:0] < 4 || k[3:0] == 5) &&
                   pins[16 * k[3:0] + 4 * (n / 4) + j[1:0]];
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_rise;
    !line_src[0] ##1 line_src[0] && en[0] && msk[0] && $past(en[0]);
  endsequence
  property p_slo_rd; s_rd(12'h400) |=> reg_rdata == $past(slo); endproperty
  property p_shi_rd; s_rd(12'h404) |=> reg_rdata == $past(shi); endproperty
  property p_plo_rd; s_rd(12'h408) |=> reg_rdata == $past(plo); endproperty
  property p_phi_rd; s_rd(12'h40C) |=> reg_rdata == $past(phi); endproperty
  property p_spare;
    reg_rd && reg_addr[11:3] == 9'h081 |=> (reg_rdata & 32'hCCCCCCCC) == 0;
  endproperty
  // Registered routing lags the pins by one cycle
  property p_route; $past(rst_b) |-> line_src == $past(exp_src); endproperty
  property p_rise; s_rise |-> ##[0:2] irq; endproperty
  property p_mask; $past(msk) == 16'h0 |-> !irq; endproperty
  a_slo_rd: assert property (p_slo_rd)
    else $error("Low port select readback wrong");
  a_shi_rd: assert property (p_shi_rd)
    else $error("High port select readback wrong");
  a_plo_rd: assert property (p_plo_rd)
    else $error("Low pin select readback wrong");
  a_phi_rd: assert property (p_phi_rd)
    else $error("High pin select readback wrong");
  a_spare: assert property (p_spare)
    else $error("Spare pin select bits read nonzero");
  a_route: assert property (p_route)
    else $error("Routed line level wrong");
  a_rise: assert property (p_rise)
    else $error("Enabled rising edge gave no interrupt");
  a_mask: assert property (p_mask)
    else $error("Interrupt high with all lines masked");
endmodule : ext_irq_checker

bind ext_irq_source_select ext_irq_checker #(.LINES(LINES)) u_ext_irq_checker (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pins(pins), .line_src(line_src), .irq(irq)
);
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench: register access, routing table and interrupt scenarios.
// Assumes the checker is bound in; the bench drives every block input.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, rst_b, reg_wr, reg_rd, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [95:0] pins;
  logic [15:0] line_src;
  int          err_total = 0;
  int          n_checks = 0;

  ext_irq_source_select #(.LINES(16)) u_ext_irq_source_select (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pins(pins), .line_src(line_src), .irq(irq)
  );
  // --------------------------------------------------------------
  // Clock, checks and bus tasks
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask : rd
  // Reference routing from register values and the pin pattern
  function automatic logic [15:0] ref_src(input logic [31:0] s0, s1, p0, p1);
    logic [15:0] r;
    logic [3:0]  k;
    logic [1:0]  j;
    for (int n = 0; n < 16; n++) begin
      k = 4'((n < 8 ? s0 : s1) >> (4 * (n % 8)));
      j = 2'((n < 8 ? p0 : p1) >> (4 * (n % 8)));
      r[n] = (k < 4 || k == 5) && pins[16 * k + 4 * (n / 4) + j];
    end
    return r;
  endfunction : ref_src
  task automatic cfg(input logic [31:0] s0, s1, p0, p1);
    wr(12'h400, s0);
    wr(12'h404, s1);
    wr(12'h408, p0);
    wr(12'h40C, p1);
    rd(12'h400, s0);
    rd(12'h404, s1);
    rd(12'h408, p0 & 32'h33333333);
    rd(12'h40C, p1 & 32'h33333333);
    chk("line_src", line_src, ref_src(s0, s1, p0, p1));
  endtask : cfg
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    // Group E is all ones so a stray route to it shows up
    pins = {16'h9C3A, 16'hFFFF, 16'hE7B1, 16'h5D28, 16'h4F96, 16'hA5C3};
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(12'h400, 32'h0);
    rd(12'h404, 32'h0);
    rd(12'h408, 32'h32103210);
    rd(12'h40C, 32'h32103210);
    rd(12'h410, 32'h0);
    chk("line_src", line_src, pins[15:0]);
    for (int c = 0; c < 16; c++) begin
      cfg(32'h11111111 * c, 32'h11111111 * c, 32'h32103210, 32'h32103210);
    end
    cfg(32'h01000000, 32'h20000003, 32'hFFFFFFFF, 32'h0);
    cfg(32'h05321003, 32'h50213000, 32'h01233210, 32'h10230132);
    cfg(32'h0, 32'h0, 32'h32103210, 32'h32103210);
    // Edge on line 0 while masked, then unmasked, then cleared
    @(posedge clk_sys);
    pins <= 96'h0;
    wr(12'h410, 32'h1);
    rd(12'h410, 32'h1);
    @(posedge clk_sys);
    pins[1:0] <= 2'b11;
    repeat (4) @(posedge clk_sys);
    rd(12'h420, 32'h1);
    chk("irq", irq, 1'b0);
    wr(12'h424, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", irq, 1'b1);
    rd(12'h424, 32'h1);
    wr(12'h420, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", irq, 1'b0);
    rd(12'h420, 32'h0);
    @(posedge clk_sys);
    pins[0] <= 1'b0;
    @(posedge clk_sys);
    pins[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("irq", irq, 1'b1);
    // Clear and a new edge in one cycle: the edge wins
    @(posedge clk_sys);
    pins[0] <= 1'b0;
    fork
      wr(12'h420, 32'h1);
      begin
        @(posedge clk_sys);
        pins[0] <= 1'b1;
      end
    join
    rd(12'h420, 32'h1);
    // Unmapped write is dropped; a second reset restores defaults
    wr(12'h7F0, 32'hFFFFFFFF);
    rd(12'h7F0, 32'h0);
    rd(12'h404, 32'h0);
    wr(12'h400, 32'h55555555);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(12'h400, 32'h0);
    rd(12'h408, 32'h32103210);
    print_verdict();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
